// >>> src/pmct_device.sv
// Purpose: command and telemetry register set of the power module
// Assumes: telemetry raw values and fault levels from the converter
// Notes: out-of-range writes are refused and flag CML
//
// The placing of the registers and the plain strobed port were decided locally.
`timescale 1ns/1ps
// Operation
// - input thresholds linear, exponent -3, positive
// - turn-on delay 10..500 ms, 0.5 ms step
// - rise time 15..500 ms, 0.5 ms step
// - timing words linear, exponent -1, positive
// - setpoint unsigned, exponent -12 via mode
// - setpoint limited 8.10 to 13.20 V
// - margin levels unsigned, exponent -12
// - store-all saves settings to nonvolatile store
// - operation bits 5:2 choose margin state
// - output voltage reading unsigned, exponent -12
// - signed output trim added, readable back
// - input reading linear, exponent -3
// - input reading corrected by gain and offset
// - current reading linear, exponent -4
// - current below 1.65 A reads zero
// - sinking current reads zero
// - current corrected by gain and offset
// - temperature linear, exponent -2, signed
// - unsupported status bits read zero
// - status word high byte summary bits
// - status word low byte summary bits
// - output voltage and current status bytes
// - host refuses an on threshold less than 2 V above the reset off level (VIN_OFF_RST)
module pmct_device
  import pmct_pkg::*;
(
  input  wire logic        I_CLK,
  input  wire logic        I_RESET,
  pmct_if.device           bus,
  input  wire logic [15:0] I_RAW_VOUT,
  input  wire logic [10:0] I_RAW_VIN,
  input  wire logic [10:0] I_RAW_IOUT,
  input  wire logic        I_IOUT_SINK,
  input  wire logic [10:0] I_RAW_TEMP,
  input  wire logic        I_VOUT_OV,
  input  wire logic        I_IOUT_OC,
  input  wire logic        I_IOUT_OCW,
  input  wire logic        I_VIN_UV,
  input  wire logic        I_TEMP_FLT,
  input  wire logic        I_PGOOD,
  input  wire logic        I_OUT_ON,
  output logic [15:0]      O_VOUT_TARGET,
  output logic [2:0]       O_MARGIN,
  output logic             O_OUT_ENABLE,
  output logic [10:0]      O_TON_DELAY,
  output logic [10:0]      O_TON_RISE,
  output logic [10:0]      O_VIN_ON,
  output logic [10:0]      O_VIN_OFF,
  output logic             O_STORE
);
  typedef struct packed {
    logic [7:0]   op;
    logic [15:0]  vout;
    logic [15:0]  mhi;
    logic [15:0]  mlo;
    logic [10:0]  von;
    logic [10:0]  voff;
    logic [10:0]  tdly;
    logic [10:0]  trise;
    logic [15:0]  vtrim;
    logic [10:0]  vin_ofs;
    logic [15:0]  vin_gain;
    logic [10:0]  io_ofs;
    logic [15:0]  io_gain;
    logic         cml;
    logic [7:0]   st_vout;
    logic [7:0]   st_iout;
    logic [15:0]  st_word;
    logic [15:0]  target;
    pmct_margin_t margin;
    logic         store;
    logic         rvalid;
    logic [15:0]  rdata;
  } pmct_dev_t;

  pmct_dev_t s_q;
  pmct_dev_t s_d;
  logic [10:0] vin_corr;
  logic [10:0] io_corr;

  // positive mantissa, saturated at its top
  function automatic logic [10:0] pos_mant(input logic [10:0] v);
    return v[10] ? 11'h3FF : v;
  endfunction

  pmct_cal #(.W(11)) u_vin_cal (
    .i_clk   (I_CLK),
    .i_reset (I_RESET),
    .i_raw   (I_RAW_VIN),
    .i_gain  (s_q.vin_gain),
    .i_ofs   (s_q.vin_ofs),
    .o_val   (vin_corr)
  );
  pmct_cal #(.W(11)) u_io_cal (
    .i_clk   (I_CLK),
    .i_reset (I_RESET),
    .i_raw   (I_RAW_IOUT),
    .i_gain  (s_q.io_gain),
    .i_ofs   (s_q.io_ofs),
    .o_val   (io_corr)
  );

  always_comb begin
    logic [10:0] m;
    logic [16:0] vsum;
    logic [10:0] iout;
    logic        acc;
    m    = bus.cmd_data[10:0];
    vsum = 17'h00000;
    iout = 11'h000;
    acc  = 1'b1;
    s_d  = s_q;
    s_d.store  = 1'b0;
    s_d.rvalid = 1'b0;
    if (bus.cmd_valid && bus.cmd_write) begin
      case (bus.cmd_code)
        CMD_OPERATION: s_d.op = {bus.cmd_data[7], 1'b0,
                                 bus.cmd_data[5:4], OP_RST[3:0]};
        CMD_CLEAR:     s_d.cml = 1'b0;
        CMD_STORE_ALL: s_d.store = 1'b1;
        CMD_VOUT_SET: begin
          acc = bus.cmd_data >= VOUT_MIN
             && bus.cmd_data <= VOUT_MAX;
          if (acc) s_d.vout = bus.cmd_data;
        end
        CMD_MARGIN_HI: s_d.mhi = bus.cmd_data;
        CMD_MARGIN_LO: s_d.mlo = bus.cmd_data;
        CMD_VIN_ON, CMD_VIN_OFF: begin
          acc = bus.cmd_data[15:11] == EXP_VIN && !m[10];
          if (acc && bus.cmd_code == CMD_VIN_ON) s_d.von = m;
          if (acc && bus.cmd_code == CMD_VIN_OFF) s_d.voff = m;
        end
        CMD_TON_DELAY: begin
          acc = bus.cmd_data[15:11] == EXP_TON
             && m >= TDLY_MIN && m <= TON_MAX;
          if (acc) s_d.tdly = m;
        end
        CMD_TON_RISE: begin
          acc = bus.cmd_data[15:11] == EXP_TON
             && m >= TRISE_MIN && m <= TON_MAX;
          if (acc) s_d.trise = m;
        end
        CMD_VOUT_TRIM: s_d.vtrim = bus.cmd_data;
        CMD_VIN_OFS:   s_d.vin_ofs = m;
        CMD_VIN_GAIN:  s_d.vin_gain = bus.cmd_data;
        CMD_IOUT_OFS:  s_d.io_ofs = m;
        CMD_IOUT_GAIN: s_d.io_gain = bus.cmd_data;
        default:       acc = 1'b0;
      endcase
      if (!acc) s_d.cml = 1'b1;
    end
    // margin state from operation bits 5:2
    case (s_q.op[5:2])
      4'b0110: s_d.margin = PMCT_MARGIN_LOW;
      4'b1010: s_d.margin = PMCT_MARGIN_HIGH;
      default: s_d.margin = PMCT_MARGIN_OFF;
    endcase
    case (s_d.margin)
      PMCT_MARGIN_LOW:  s_d.target = s_q.mlo;
      PMCT_MARGIN_HIGH: s_d.target = s_q.mhi;
      default:          s_d.target = s_q.vout;
    endcase
    s_d.st_vout = '0;
    s_d.st_vout[SV_OV] = I_VOUT_OV;
    s_d.st_iout = '0;
    s_d.st_iout[SI_OC]  = I_IOUT_OC;
    s_d.st_iout[SI_OCW] = I_IOUT_OCW;
    s_d.st_word = '0;
    s_d.st_word[SW_VOUT] = |s_d.st_vout;
    s_d.st_word[SW_IOUT] = |s_d.st_iout;
    s_d.st_word[SW_VIN]  = I_VIN_UV;
    s_d.st_word[SW_PGN]  = !I_PGOOD;
    s_d.st_word[SW_OFF]  = !I_OUT_ON;
    s_d.st_word[SW_OV]   = I_VOUT_OV;
    s_d.st_word[SW_OC]   = I_IOUT_OC;
    s_d.st_word[SW_UV]   = I_VIN_UV;
    s_d.st_word[SW_TEMP] = I_TEMP_FLT;
    s_d.st_word[SW_CML]  = s_q.cml;
    s_d.st_word = s_d.st_word & SW_SUPPORTED;
    vsum = {1'b0, I_RAW_VOUT} + {s_q.vtrim[15], s_q.vtrim};
    if (I_IOUT_SINK || io_corr < IOUT_BLANK)
      iout = 11'h000;
    else
      iout = io_corr;
    if (bus.cmd_valid && !bus.cmd_write) begin
      s_d.rvalid = 1'b1;
      case (bus.cmd_code)
        CMD_OPERATION:   s_d.rdata = {8'h00, s_q.op};
        CMD_VOUT_MODE:   s_d.rdata = {8'h00, VOUT_MODE_VAL};
        CMD_VOUT_SET:    s_d.rdata = s_q.vout;
        CMD_MARGIN_HI:   s_d.rdata = s_q.mhi;
        CMD_MARGIN_LO:   s_d.rdata = s_q.mlo;
        CMD_VIN_ON:      s_d.rdata = pmct_lin(EXP_VIN, s_q.von);
        CMD_VIN_OFF:     s_d.rdata = pmct_lin(EXP_VIN, s_q.voff);
        CMD_TON_DELAY:   s_d.rdata = pmct_lin(EXP_TON, s_q.tdly);
        CMD_TON_RISE:    s_d.rdata = pmct_lin(EXP_TON, s_q.trise);
        CMD_STATUS_WORD: s_d.rdata = s_q.st_word;
        CMD_STATUS_OUTPUT_VOLTAGE: s_d.rdata = {8'h00, s_q.st_vout};
        CMD_STATUS_OUTPUT_CURRENT: s_d.rdata = {8'h00, s_q.st_iout};
        CMD_READ_VOUT:
          if (vsum[16])
            s_d.rdata = s_q.vtrim[15] ? 16'h0000 : 16'hFFFF;
          else
            s_d.rdata = vsum[15:0];
        CMD_READ_VIN:
          s_d.rdata = pmct_lin(EXP_VIN, pos_mant(vin_corr));
        CMD_READ_IOUT:
          s_d.rdata = pmct_lin(EXP_IOUT, pos_mant(iout));
        CMD_READ_TEMP:   s_d.rdata = pmct_lin(EXP_TEMP, I_RAW_TEMP);
        CMD_VOUT_TRIM:   s_d.rdata = s_q.vtrim;
        CMD_VIN_OFS:     s_d.rdata = pmct_lin(EXP_VIN, s_q.vin_ofs);
        CMD_VIN_GAIN:    s_d.rdata = s_q.vin_gain;
        CMD_IOUT_OFS:    s_d.rdata = pmct_lin(EXP_IOUT, s_q.io_ofs);
        CMD_IOUT_GAIN:   s_d.rdata = s_q.io_gain;
        default: begin
          s_d.rdata = 16'h0000;
          s_d.cml   = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      s_q <= '{op: OP_RST, vout: VOUT_RST, mhi: MHI_RST, mlo: MLO_RST,
               von: VIN_ON_RST, voff: VIN_OFF_RST, tdly: TDLY_RST,
               trise: TRISE_RST, vtrim: 16'h0000, vin_ofs: 11'h000,
               vin_gain: GAIN_UNITY, io_ofs: 11'h000,
               io_gain: GAIN_UNITY, cml: 1'b0, st_vout: 8'h00,
               st_iout: 8'h00, st_word: 16'h0000, target: VOUT_RST,
               margin: PMCT_MARGIN_OFF, store: 1'b0, rvalid: 1'b0,
               rdata: 16'h0000};
    end else begin
      s_q <= s_d;
    end
  end

  assign bus.rsp_valid  = s_q.rvalid;
  assign bus.rsp_data   = s_q.rdata;
  assign O_VOUT_TARGET  = s_q.target;
  assign O_MARGIN       = s_q.margin;
  assign O_OUT_ENABLE   = s_q.op[7];
  assign O_TON_DELAY    = s_q.tdly;
  assign O_TON_RISE     = s_q.trise;
  assign O_VIN_ON       = s_q.von;
  assign O_VIN_OFF      = s_q.voff;
  assign O_STORE        = s_q.store;
endmodule

// >>> src/pmct_pkg.sv
// Purpose: shared constants for the power module command/telemetry set
// Assumes: one 25 MHz clock, synchronous active-high reset
// Notes: command codes follow the bus command set
package pmct_pkg;
  localparam logic [7:0] CMD_OPERATION   = 8'h01;
  localparam logic [7:0] CMD_CLEAR       = 8'h03;
  localparam logic [7:0] CMD_STORE_ALL   = 8'h11;
  localparam logic [7:0] CMD_VOUT_MODE   = 8'h20;
  localparam logic [7:0] CMD_VOUT_SET    = 8'h21;
  localparam logic [7:0] CMD_MARGIN_HI   = 8'h25;
  localparam logic [7:0] CMD_MARGIN_LO   = 8'h26;
  localparam logic [7:0] CMD_VIN_ON      = 8'h35;
  localparam logic [7:0] CMD_VIN_OFF     = 8'h36;
  localparam logic [7:0] CMD_TON_DELAY   = 8'h60;
  localparam logic [7:0] CMD_TON_RISE    = 8'h61;
  localparam logic [7:0] CMD_STATUS_WORD = 8'h79;
  localparam logic [7:0] CMD_STATUS_OUTPUT_VOLTAGE = 8'h7A;
  localparam logic [7:0] CMD_STATUS_OUTPUT_CURRENT = 8'h7B;
  localparam logic [7:0] CMD_READ_VIN    = 8'h88;
  localparam logic [7:0] CMD_READ_VOUT   = 8'h8B;
  localparam logic [7:0] CMD_READ_IOUT   = 8'h8C;
  localparam logic [7:0] CMD_READ_TEMP   = 8'h8D;
  localparam logic [7:0] CMD_VOUT_TRIM   = 8'hD0;
  localparam logic [7:0] CMD_VIN_OFS     = 8'hD1;
  localparam logic [7:0] CMD_VIN_GAIN    = 8'hD2;
  localparam logic [7:0] CMD_IOUT_OFS    = 8'hD3;
  localparam logic [7:0] CMD_IOUT_GAIN   = 8'hD4;
  // linear exponents, 5-bit two's complement
  localparam logic [4:0] EXP_VIN  = 5'h1D;
  localparam logic [4:0] EXP_TON  = 5'h1F;
  localparam logic [4:0] EXP_IOUT = 5'h1C;
  localparam logic [4:0] EXP_TEMP = 5'h1E;
  localparam logic [7:0] VOUT_MODE_VAL = 8'h14;
  // setpoint limits in 2^-12 V counts (8.10 V, 13.20 V)
  localparam logic [15:0] VOUT_MIN = 16'h8199;
  localparam logic [15:0] VOUT_MAX = 16'hD333;
  localparam logic [15:0] VOUT_RST = 16'hC000;
  localparam logic [15:0] MHI_RST  = 16'hC000;
  localparam logic [15:0] MLO_RST  = 16'hC000;
  // times in 0.5 ms counts: 10/500 ms delay, 15/500 ms rise
  localparam logic [10:0] TDLY_MIN = 11'h014;
  localparam logic [10:0] TRISE_MIN = 11'h01E;
  localparam logic [10:0] TON_MAX  = 11'h3E8;
  localparam logic [10:0] TDLY_RST = 11'h014;
  localparam logic [10:0] TRISE_RST = 11'h01E;
  // input thresholds in 0.125 V counts
  localparam logic [10:0] VIN_ON_RST  = 11'h118;
  localparam logic [10:0] VIN_OFF_RST = 11'h100;
  // blanking 1.65 A in 1/16 A counts, rounded up
  localparam logic [10:0] IOUT_BLANK = 11'h01B;
  localparam logic [15:0] GAIN_UNITY = 16'h2000;
  localparam int          GAIN_SHIFT = 13;
  localparam logic [7:0]  OP_RST     = 8'h88;
  // status bit positions
  localparam int SW_VOUT = 15;
  localparam int SW_IOUT = 14;
  localparam int SW_VIN  = 13;
  localparam int SW_PGN  = 11;
  localparam int SW_OFF  = 6;
  localparam int SW_OV   = 5;
  localparam int SW_OC   = 4;
  localparam int SW_UV   = 3;
  localparam int SW_TEMP = 2;
  localparam int SW_CML  = 1;
  localparam int SV_OV   = 7;
  localparam int SI_OC   = 7;
  localparam int SI_OCW  = 5;
  localparam logic [15:0] SW_SUPPORTED = 16'hE87E;

  typedef enum logic [2:0] {
    PMCT_MARGIN_OFF  = 3'b001,
    PMCT_MARGIN_LOW  = 3'b010,
    PMCT_MARGIN_HIGH = 3'b100
  } pmct_margin_t;

  function automatic logic [15:0] pmct_lin(input logic [4:0]  e,
                                           input logic [10:0] m);
    return {e, m};
  endfunction
endpackage

// >>> src/pmct_if.sv
// Purpose: command/answer path between host and power module
// Assumes: single clock, host issues one command at a time
// Notes: rsp_valid pulses one cycle after a read command
`timescale 1ns/1ps
interface pmct_if;
  logic        cmd_valid;
  logic        cmd_write;
  logic [7:0]  cmd_code;
  logic [15:0] cmd_data;
  logic        rsp_valid;
  logic [15:0] rsp_data;
  modport device (input cmd_valid, input cmd_write, input cmd_code,
                  input cmd_data, output rsp_valid, output rsp_data);
  modport host (output cmd_valid, output cmd_write, output cmd_code,
                output cmd_data, input rsp_valid, input rsp_data);
endinterface

// >>> src/pmct_cal.sv
// Purpose: gain/offset correction of one raw reading
// Assumes: raw and result unsigned, offset two's complement
// Notes: negative results clip to zero
`timescale 1ns/1ps
module pmct_cal
  import pmct_pkg::*;
#(
  parameter int W = 11
) (
  input  wire logic         i_clk,
  input  wire logic         i_reset,
  input  wire logic [W-1:0] i_raw,
  input  wire logic [15:0]  i_gain,
  input  wire logic [W-1:0] i_ofs,
  output logic      [W-1:0] o_val
);
  logic [W+15:0] prod;
  logic [W+3:0]  sum;
  logic [W-1:0]  val_q;
  always_comb begin
    prod = i_raw * i_gain;
    sum  = {1'b0, prod[W+15:GAIN_SHIFT]}
         + {{4{i_ofs[W-1]}}, i_ofs};
  end
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      val_q <= '0;
    end else if (sum[W+3]) begin
      val_q <= '0;
    end else if (|sum[W+2:W]) begin
      val_q <= '1;
    end else begin
      val_q <= sum[W-1:0];
    end
  end
  assign o_val = val_q;
endmodule

// >>> src/pmct_host.sv
// Purpose: host end issuing commands from a software port
// Assumes: software waits for done before a second read
// Notes: addr is the command code
`timescale 1ns/1ps
module pmct_host
  import pmct_pkg::*;
(
  input  wire logic        I_CLK,
  input  wire logic        I_RESET,
  pmct_if.host             bus,
  input  wire logic [7:0]  I_ADDR,
  input  wire logic [15:0] I_WDATA,
  input  wire logic        I_WR,
  input  wire logic        I_RD,
  output logic [15:0]      O_RDATA,
  output logic             O_RVALID,
  output logic             O_REFUSED
);
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [7:0]  code;
    logic [15:0] data;
    logic [15:0] rdata;
    logic        rvalid;
    logic        refused;
  } pmct_host_t;

  pmct_host_t h_q;
  pmct_host_t h_d;
  logic       gap_bad;

  always_comb begin
    h_d = h_q;
    h_d.valid  = 1'b0;
    h_d.rvalid = bus.rsp_valid;
    if (bus.rsp_valid) h_d.rdata = bus.rsp_data;
    // hysteresis guard on input thresholds
    gap_bad = 1'b0;
    if (I_WR && I_ADDR == CMD_VIN_ON)
      gap_bad = I_WDATA[10:0] < VIN_OFF_RST + 11'h010;
    h_d.refused = gap_bad;
    if ((I_WR || I_RD) && !gap_bad) begin
      h_d.valid = 1'b1;
      h_d.write = I_WR;
      h_d.code  = I_ADDR;
      h_d.data  = I_WDATA;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      h_q <= '0;
    end else begin
      h_q <= h_d;
    end
  end

  assign bus.cmd_valid = h_q.valid;
  assign bus.cmd_write = h_q.write;
  assign bus.cmd_code  = h_q.code;
  assign bus.cmd_data  = h_q.data;
  assign O_RDATA   = h_q.rdata;
  assign O_RVALID  = h_q.rvalid;
  assign O_REFUSED = h_q.refused;
endmodule

// >>> verification/pmct_props.sv
// Purpose: link checks between host and device ends
// Assumes: one clock, sync active-high reset
// Notes: sees only the link signals
`timescale 1ns/1ps
module pmct_props
  import pmct_pkg::*;
(
  input wire logic        I_CLK,
  input wire logic        I_RESET,
  input wire logic        cmd_valid,
  input wire logic        cmd_write,
  input wire logic [7:0]  cmd_code,
  input wire logic [15:0] cmd_data,
  input wire logic        rsp_valid,
  input wire logic [15:0] rsp_data
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RESET);
  logic rd_cmd;
  assign rd_cmd = cmd_valid && !cmd_write;
  read_answer_a: assert property (rd_cmd |=> rsp_valid)
    else $error("no answer to read");
  write_silent_a: assert property (cmd_valid && cmd_write |=> !rsp_valid)
    else $error("answer to write");
  answer_cause_a: assert property (rsp_valid |-> $past(rd_cmd))
    else $error("answer without read");
  mode_exp_a: assert property (rd_cmd && cmd_code == CMD_VOUT_MODE
    |=> rsp_data == 16'h0014) else $error("bad mode word");
  vin_fmt_a: assert property (rd_cmd && cmd_code == CMD_READ_VIN
    |=> rsp_data[15:10] == {EXP_VIN, 1'h0}) else $error("bad vin word");
  iout_fmt_a: assert property (rd_cmd && cmd_code == CMD_READ_IOUT
    |=> rsp_data[15:10] == {EXP_IOUT, 1'h0}) else $error("bad iout word");
  temp_fmt_a: assert property (rd_cmd && cmd_code == CMD_READ_TEMP
    |=> rsp_data[15:11] == EXP_TEMP) else $error("bad temp word");
  thresh_fmt_a: assert property (rd_cmd && (cmd_code == CMD_VIN_ON
    || cmd_code == CMD_VIN_OFF) |=> rsp_data[15:10] == {EXP_VIN, 1'h0})
    else $error("bad threshold word");
  timing_fmt_a: assert property (rd_cmd && (cmd_code == CMD_TON_DELAY
    || cmd_code == CMD_TON_RISE) |=> rsp_data[15:10] == {EXP_TON, 1'h0})
    else $error("bad timing word");
  status_zero_a: assert property (rd_cmd && cmd_code == CMD_STATUS_WORD
    |=> (rsp_data & ~SW_SUPPORTED) == 16'h0000) else $error("bad word bit");
  vout_byte_a: assert property (rd_cmd && cmd_code == CMD_STATUS_OUTPUT_VOLTAGE
    |=> (rsp_data & 16'hFF7F) == 16'h0000) else $error("bad vout bit");
  iout_byte_a: assert property (rd_cmd && cmd_code == CMD_STATUS_OUTPUT_CURRENT
    |=> (rsp_data & 16'hFF5F) == 16'h0000) else $error("bad iout bit");
endmodule

// >>> verification/power_module_cmd_telemetry_bench.sv
// Purpose: self-checking bench for the host and device ends
// Assumes: 25 MHz clock, reset held for 8 cycles
// Notes: software port drives the host, converter inputs the device
`timescale 1ns/1ps
module power_module_cmd_telemetry_bench
  import pmct_pkg::*;
;
  logic        clk = 1'h0;
  logic        rst = 1'h1;
  logic [7:0]  addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic        wr = 1'h0;
  logic        rd = 1'h0;
  logic [15:0] rdata;
  logic        rvalid;
  logic        refused;
  logic        ref_q;
  logic [15:0] raw_vout = 16'h0000;
  logic [10:0] raw_vin = 11'h000;
  logic [10:0] raw_iout = 11'h000;
  logic [10:0] raw_temp = 11'h000;
  logic        sink = 1'h0;
  logic [6:0]  flt = 7'h00;
  logic [15:0] vtgt;
  logic [2:0]  marg;
  logic        oen;
  logic        store;
  logic [10:0] tdly;
  logic [10:0] trise;
  logic [10:0] von;
  logic [10:0] voff;
  int          num_errors = 0;
  int          checks = 0;
  int          n_store = 0;
  // code, word written, word read back
  logic [39:0] set_tbl [12] = '{
    40'h60_F814_F814, 40'h60_F813_F814, 40'h60_FBE8_FBE8, 40'h60_FBE9_FBE8,
    40'h60_E814_FBE8, 40'h61_F81E_F81E, 40'h61_F81D_F81E, 40'h61_FBE8_FBE8,
    40'h21_8199_8199, 40'h21_8198_8199, 40'h21_D334_8199, 40'h21_D333_D333};
  // operation, read back, margin, enable, target
  logic [39:0] op_tbl [4] = '{40'hA8_A8_4_1_D000, 40'h98_98_2_1_9000,
    40'h84_88_1_1_D333, 40'h28_28_4_0_D000};
  // status word, vout byte, iout byte for each single fault
  logic [47:0] st_tbl [7] = '{48'h8020_0080_0000, 48'h4010_0000_0080,
    48'h4000_0000_0020, 48'h2008_0000_0000, 48'h0004_0000_0000,
    48'h0800_0000_0000, 48'h0040_0000_0000};
  pmct_if lnk ();
  pmct_host u_pmct_host (.I_CLK(clk), .I_RESET(rst), .bus(lnk),
    .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd),
    .O_RDATA(rdata), .O_RVALID(rvalid), .O_REFUSED(refused));
  pmct_device u_pmct_device (.I_CLK(clk), .I_RESET(rst), .bus(lnk),
    .I_RAW_VOUT(raw_vout), .I_RAW_VIN(raw_vin), .I_RAW_IOUT(raw_iout),
    .I_IOUT_SINK(sink), .I_RAW_TEMP(raw_temp), .I_VOUT_OV(flt[6]),
    .I_IOUT_OC(flt[5]), .I_IOUT_OCW(flt[4]), .I_VIN_UV(flt[3]),
    .I_TEMP_FLT(flt[2]), .I_PGOOD(!flt[1]), .I_OUT_ON(!flt[0]),
    .O_VOUT_TARGET(vtgt), .O_MARGIN(marg), .O_OUT_ENABLE(oen),
    .O_TON_DELAY(tdly), .O_TON_RISE(trise), .O_VIN_ON(von),
    .O_VIN_OFF(voff), .O_STORE(store));
  pmct_props u_pmct_props (.I_CLK(clk), .I_RESET(rst),
    .cmd_valid(lnk.cmd_valid), .cmd_write(lnk.cmd_write),
    .cmd_code(lnk.cmd_code), .cmd_data(lnk.cmd_data),
    .rsp_valid(lnk.rsp_valid), .rsp_data(lnk.rsp_data));
  always #20 clk = ~clk;
  always @(posedge clk) if (store === 1'h1) n_store <= n_store + 1;
  task automatic give_verdict;
    if (num_errors == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    addr  <= a;
    wdata <= d;
    wr    <= 1'h1;
    @(posedge clk);
    wr <= 1'h0;
    @(posedge clk);
    ref_q = refused;
    @(posedge clk);
    ref_q = ref_q | refused;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
    int n;
    @(posedge clk);
    addr <= a;
    rd   <= 1'h1;
    @(posedge clk);
    rd <= 1'h0;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (rvalid !== 1'h1 && n < 8);
    chk({15'h0000, rvalid}, 16'h0001);
    chk(rdata, e);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    rd_chk(CMD_STATUS_WORD, 16'h0000);
    rd_chk(CMD_STATUS_OUTPUT_VOLTAGE, 16'h0000);
    rd_chk(CMD_STATUS_OUTPUT_CURRENT, 16'h0000);
    chk({13'h0000, marg}, 16'h0001);
    rd_chk(CMD_VOUT_MODE, 16'h0014);
    wr_reg(CMD_VIN_ON, 16'hE920);
    wr_reg(CMD_VIN_OFF, 16'hE908);
    wr_reg(CMD_VIN_ON, 16'hE90F);
    chk({15'h0000, ref_q}, 16'h0001);
    rd_chk(CMD_VIN_ON, 16'hE920);
    rd_chk(CMD_VIN_OFF, 16'hE908);
    chk({5'h00, von}, 16'h0120);
    chk({5'h00, voff}, 16'h0108);
    for (int i = 0; i < 12; i++) begin
      wr_reg(set_tbl[i][39:32], set_tbl[i][31:16]);
      rd_chk(set_tbl[i][39:32], set_tbl[i][15:0]);
    end
    chk({5'h00, tdly}, 16'h03E8);
    chk({5'h00, trise}, 16'h03E8);
    chk(vtgt, 16'hD333);
    rd_chk(CMD_STATUS_WORD, 16'h0002);
    wr_reg(CMD_CLEAR, 16'h0000);
    rd_chk(CMD_STATUS_WORD, 16'h0000);
    wr_reg(CMD_MARGIN_HI, 16'hD000);
    wr_reg(CMD_MARGIN_LO, 16'h9000);
    rd_chk(CMD_MARGIN_HI, 16'hD000);
    rd_chk(CMD_MARGIN_LO, 16'h9000);
    for (int i = 0; i < 4; i++) begin
      wr_reg(CMD_OPERATION, {8'h00, op_tbl[i][39:32]});
      rd_chk(CMD_OPERATION, {8'h00, op_tbl[i][31:24]});
      chk({13'h0000, marg}, {12'h000, op_tbl[i][23:20]});
      chk({15'h0000, oen}, {12'h000, op_tbl[i][19:16]});
      chk(vtgt, op_tbl[i][15:0]);
    end
    wr_reg(CMD_STORE_ALL, 16'h0000);
    repeat (4) @(posedge clk);
    chk(n_store[15:0], 16'h0001);
    raw_vout <= 16'hC000;
    rd_chk(CMD_READ_VOUT, 16'hC000);
    wr_reg(CMD_VOUT_TRIM, 16'hFFF0);
    rd_chk(CMD_VOUT_TRIM, 16'hFFF0);
    rd_chk(CMD_READ_VOUT, 16'hBFF0);
    raw_vout <= 16'h0008;
    rd_chk(CMD_READ_VOUT, 16'h0000);
    wr_reg(CMD_VOUT_TRIM, 16'h0010);
    raw_vout <= 16'hFFF8;
    rd_chk(CMD_READ_VOUT, 16'hFFFF);
    raw_vin <= 11'h180;
    rd_chk(CMD_READ_VIN, 16'hE980);
    wr_reg(CMD_VIN_GAIN, 16'h3000);
    wr_reg(CMD_VIN_OFS, 16'hE808);
    raw_vin <= 11'h100;
    rd_chk(CMD_READ_VIN, 16'hE988);
    rd_chk(CMD_VIN_OFS, 16'hE808);
    rd_chk(CMD_VIN_GAIN, 16'h3000);
    raw_vin <= 11'h7FF;
    rd_chk(CMD_READ_VIN, 16'hEBFF);
    raw_iout <= 11'h040;
    rd_chk(CMD_READ_IOUT, 16'hE040);
    raw_iout <= 11'h01A;
    rd_chk(CMD_READ_IOUT, 16'hE000);
    raw_iout <= 11'h01B;
    rd_chk(CMD_READ_IOUT, 16'hE01B);
    raw_iout <= 11'h040;
    sink <= 1'h1;
    rd_chk(CMD_READ_IOUT, 16'hE000);
    sink <= 1'h0;
    wr_reg(CMD_IOUT_GAIN, 16'h4000);
    wr_reg(CMD_IOUT_OFS, 16'hE002);
    raw_iout <= 11'h020;
    rd_chk(CMD_READ_IOUT, 16'hE042);
    rd_chk(CMD_IOUT_OFS, 16'hE002);
    rd_chk(CMD_IOUT_GAIN, 16'h4000);
    raw_temp <= 11'h7F8;
    rd_chk(CMD_READ_TEMP, 16'hF7F8);
    wr_reg(CMD_OPERATION, 16'h0088);
    rd_chk(8'h55, 16'h0000);
    rd_chk(CMD_STATUS_WORD, 16'h0002);
    wr_reg(CMD_CLEAR, 16'h0000);
    wr_reg(8'h55, 16'h1234);
    rd_chk(CMD_STATUS_WORD, 16'h0002);
    wr_reg(CMD_CLEAR, 16'h0000);
    for (int i = 0; i < 7; i++) begin
      flt <= 7'h40 >> i;
      rd_chk(CMD_STATUS_WORD, st_tbl[i][47:32]);
      rd_chk(CMD_STATUS_OUTPUT_VOLTAGE, st_tbl[i][31:16]);
      rd_chk(CMD_STATUS_OUTPUT_CURRENT, st_tbl[i][15:0]);
    end
    flt <= 7'h00;
    rd_chk(CMD_STATUS_WORD, 16'h0000);
    give_verdict();
  end
  initial begin
    repeat (6000) @(posedge clk);
    num_errors++;
    give_verdict();
  end
endmodule
